// ---- flwb_core.sv ----
// Status, write-latch, ECC status read and boot read logic of a serial flash.
// Assumes the host frames every transfer with cs_n and clocks sck only inside
// frames; boot_data and ecc_status come from array logic on sck.
`include "flwb_params.svh"
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Set-write-enable instruction sets the write enable latch, status bit 1.
// - Write, program or erase commands are refused unless the latch is set.
// - Latch instructions run only if chip select rises right after bit eight.
// - Clear-write-enable instruction clears the latch, blocking later writes.
// - Clear-write-enable is ignored while write-in-progress reads one.
// - Clear-fail-flags instruction resets erase flag bit 5, program flag bit 6.
// - Clear-fail-flags needs no latch, works while busy, leaves latch alone.
// - Write-in-progress stays one while either failure flag is set.
// - After address, eight dummy cycles, then unit status byte sent 16 times.
// - Next ECC units follow, 16 times each, until chip select rises.
// - With boot enabled, finishing any reset arms the automatic boot read.
// - Boot output is held back for the 8-bit start delay count.
// - Boot read starts at the 23-bit start address, 512-byte aligned.
// - Boot data keeps streaming while chip select stays low.
// - Chip select rising after the first boot byte ends boot mode.
// - After boot mode ends, no new boot read until the next reset.
// - Quad bit set gives four bits per clock, clear gives single-bit boot.
// - Quad mode disables hardware write protection on data line two.
// - Boot configuration is 32 bits, written least significant byte first.
module flwb_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output var logic [3:0] io_out_q,
  output var logic [3:0] io_oe_q,
  input wire logic quad_enable,
  input wire logic embedded_busy,
  input wire logic program_fail_evt,
  input wire logic erase_fail_evt,
  input wire logic cmd_reset_evt,
  input wire logic [7:0] boot_data,
  input wire logic [7:0] ecc_status,
  output var logic [31:0] boot_offset_q,
  output var logic [31:0] boot_base_q,
  output var logic [19:0] ecc_unit_q,
  output var logic [7:0] status_register_one_q,
  output var logic [31:0] boot_config_q,
  output var logic boot_armed_q,
  output var logic hw_protect_q
);
  import flwb_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Link domain. Only sck edges inside a frame move this logic; cs_n high
  // clears the frame marker and the pin drivers. Configuration, quad and
  // armed flags from the core change only between frames, so they are
  // stable whenever sck runs and are read here without a synchroniser.

  logic frame_q;
  logic [5:0] cnt_q;
  logic [39:0] sh_q;
  logic fr_boot_q;
  logic fr_byte_q;
  flwb_link_st_t st_q;
  logic [7:0] dly_q;
  logic [2:0] bbit_q;
  logic [7:0] bbyte_q;
  logic [2:0] ebit_q;
  logic [3:0] rep_q;
  logic quad_q;

  wire first = !frame_q;
  wire [5:0] cnt_d = first ? 6'h01 : ((cnt_q == 6'h3f) ? cnt_q : cnt_q + 6'h01);
  wire [39:0] sh_d = first ? {39'h0, io_in[0]} : {sh_q[38:0], io_in[0]};
  wire [7:0] start_dly = boot_config_q[`FLWB_CFG_DLY_MSB:`FLWB_CFG_DLY_LSB];

  wire boot_emit = (first && boot_armed_q && start_dly == 8'h00) ||
                   (!first && st_q == st_boot_dly && dly_q == 8'h00) ||
                   (!first && st_q == st_boot_data);
  wire ecc_emit = !first && st_q == st_ecc_data;
  wire [7:0] boot_cur = (bbit_q == 3'h0) ? boot_data : bbyte_q;
  wire boot_last = quad_q ? (bbit_q == 3'h1) : (bbit_q == 3'h7);
  wire [3:0] boot_nib = bbit_q[0] ? boot_cur[3:0] : boot_cur[7:4];
  wire boot_bit = boot_cur[3'h7 - bbit_q];
  wire [3:0] boot_out = quad_q ? boot_nib : {2'b00, boot_bit, 1'b0};
  wire [3:0] boot_oe = quad_q ? 4'hf : 4'h2;
  wire ecc_bit = ecc_status[3'h7 - ebit_q];

  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      frame_q <= 1'b0;
    end else begin
      frame_q <= 1'b1;
    end
  end

  // Kept across the rising cs_n so that the core can judge the frame.
  always_ff @(posedge sck) begin
    cnt_q <= cnt_d;
    sh_q <= sh_d;
    if (first) begin
      fr_boot_q <= boot_armed_q;
    end
  end

  always_ff @(posedge sck) begin
    if (first) begin
      fr_byte_q <= 1'b0;
    end else if (boot_emit && boot_last) begin
      fr_byte_q <= 1'b1;
    end
  end

  always_ff @(posedge sck) begin
    if (first) begin
      if (!boot_armed_q) begin
        st_q <= st_cmd;
      end else if (start_dly == 8'h00) begin
        st_q <= st_boot_data;
      end else begin
        st_q <= st_boot_dly;
        dly_q <= start_dly - 8'h01;
      end
    end else begin
      case (st_q)
        st_cmd: begin
          if (cnt_d == 6'(`FLWB_CMD_BITS) && sh_d[7:0] == ecc_status_read_cmd) begin
            st_q <= st_ecc_addr;
          end
        end
        st_ecc_addr: begin
          if (cnt_d == 6'(`FLWB_CMD_BITS + `FLWB_ADDR_BITS)) begin
            st_q <= st_ecc_dummy;
            dly_q <= 8'(`FLWB_ECC_DUMMY - 1);
          end
        end
        st_ecc_dummy: begin
          if (dly_q == 8'h00) begin
            st_q <= st_ecc_data;
          end else begin
            dly_q <= dly_q - 8'h01;
          end
        end
        st_boot_dly: begin
          if (dly_q == 8'h00) begin
            st_q <= st_boot_data;
          end else begin
            dly_q <= dly_q - 8'h01;
          end
        end
        st_ecc_data, st_boot_data: begin
          st_q <= st_q;
        end
        default: begin
          st_q <= st_cmd;
        end
      endcase
    end
  end

  // Boot stream: a byte is taken from the array when its first bit goes out.
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bbit_q <= 3'h0;
      boot_offset_q <= 32'h0000_0000;
    end else if (boot_emit) begin
      if (bbit_q == 3'h0) begin
        bbyte_q <= boot_data;
      end
      if (boot_last) begin
        bbit_q <= 3'h0;
        boot_offset_q <= boot_offset_q + 32'h0000_0001;
      end else begin
        bbit_q <= bbit_q + 3'h1;
      end
    end
  end

  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      ebit_q <= 3'h0;
      rep_q <= 4'h0;
      ecc_unit_q <= 20'h0_0000;
    end else if (!first && st_q == st_ecc_addr &&
                 cnt_d == 6'(`FLWB_CMD_BITS + `FLWB_ADDR_BITS)) begin
      ecc_unit_q <= sh_d[`FLWB_ADDR_BITS-1:`FLWB_ECC_UNIT_LSB];
    end else if (ecc_emit) begin
      ebit_q <= ebit_q + 3'h1;
      if (ebit_q == 3'h7) begin
        if (rep_q == 4'(`FLWB_ECC_REPEAT - 1)) begin
          rep_q <= 4'h0;
          ecc_unit_q <= ecc_unit_q + 20'h0_0001;
        end else begin
          rep_q <= rep_q + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      io_out_q <= 4'h0;
      io_oe_q <= 4'h0;
    end else if (boot_emit) begin
      io_out_q <= boot_out;
      io_oe_q <= boot_oe;
    end else if (ecc_emit) begin
      io_out_q <= {2'b00, ecc_bit, 1'b0};
      io_oe_q <= 4'h2;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Core domain. A frame is judged when the filtered cs_n rises; by then sck
  // has stopped, so the link snapshot registers are quiet.

  logic [1:0] pin_f;
  logic cs_prev_q;
  logic latch_q;
  logic p_err_q;
  logic e_err_q;
  logic busy_q;
  logic [15:0] busy_cnt_q;
  logic [31:0] pend_cfg_q;
  logic rearm_q;

  flwb_sync #(.W(2), .RST_VAL(2'b11)) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({cs_n, io_in[2]}),
    .q(pin_f)
  );

  wire cs_rise = pin_f[1] && !cs_prev_q;
  wire in_prog = busy_q || embedded_busy || p_err_q || e_err_q;
  wire cmd_frame = cs_rise && !fr_boot_q;
  wire is_byte = cnt_q == 6'(`FLWB_CMD_BITS);
  wire is_cfg_wr = cnt_q == 6'(`FLWB_CFG_WR_BITS);
  wire do_set_we = cmd_frame && is_byte && sh_q[7:0] == set_write_enable_cmd;
  wire do_clr_we = cmd_frame && is_byte && sh_q[7:0] == clear_write_enable_cmd && !in_prog;
  wire do_clr_fail = cmd_frame && is_byte && sh_q[7:0] == clear_fail_flags_cmd;
  wire do_cfg_wr = cmd_frame && is_cfg_wr && sh_q[39:32] == boot_config_write_cmd &&
                   latch_q && !in_prog;
  wire cfg_done = busy_q && busy_cnt_q == 16'h0000;
  wire [31:0] cfg_in = {sh_q[7:0], sh_q[15:8], sh_q[23:16], sh_q[31:24]};
  wire boot_over = cs_rise && fr_boot_q && fr_byte_q;
  wire [7:0] sr_d = (8'(in_prog) << `FLWB_STAT_BUSY) | (8'(latch_q) << `FLWB_STAT_LATCH) |
                    (8'(e_err_q) << `FLWB_STAT_EFAIL) | (8'(p_err_q) << `FLWB_STAT_PFAIL);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_prev_q <= 1'b1;
      latch_q <= 1'b0;
    end else begin
      cs_prev_q <= pin_f[1];
      if (do_set_we) begin
        latch_q <= 1'b1;
      end else if (do_clr_we || cfg_done) begin
        latch_q <= 1'b0;
      end
    end
  end

  // A failure event in the same cycle as the clear keeps its flag set.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      p_err_q <= 1'b0;
      e_err_q <= 1'b0;
    end else begin
      p_err_q <= program_fail_evt || (p_err_q && !do_clr_fail);
      e_err_q <= erase_fail_evt || (e_err_q && !do_clr_fail);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      busy_cnt_q <= 16'h0000;
      pend_cfg_q <= `FLWB_CFG_RESET;
      boot_config_q <= `FLWB_CFG_RESET;
    end else if (do_cfg_wr) begin
      busy_q <= 1'b1;
      busy_cnt_q <= 16'(`FLWB_CFG_WR_CYCLES - 1);
      pend_cfg_q <= cfg_in;
    end else if (cfg_done) begin
      busy_q <= 1'b0;
      boot_config_q <= pend_cfg_q;
    end else if (busy_q) begin
      busy_cnt_q <= busy_cnt_q - 16'h0001;
    end
  end

  // Arming waits one cycle after reset so the enable bit is read settled.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rearm_q <= 1'b1;
      boot_armed_q <= 1'b0;
    end else if (rearm_q) begin
      rearm_q <= 1'b0;
      boot_armed_q <= boot_config_q[`FLWB_CFG_BOOT_EN];
    end else if (cmd_reset_evt) begin
      rearm_q <= 1'b1;
      boot_armed_q <= 1'b0;
    end else if (boot_over) begin
      boot_armed_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      quad_q <= 1'b0;
      hw_protect_q <= 1'b0;
      status_register_one_q <= 8'h00;
      boot_base_q <= 32'h0000_0000;
    end else begin
      quad_q <= quad_enable;
      hw_protect_q <= !quad_q && !pin_f[0];
      status_register_one_q <= sr_d;
      boot_base_q <= {boot_config_q[`FLWB_CFG_ADDR_MSB:`FLWB_CFG_ADDR_LSB],
                      9'h000};
    end
  end

endmodule

`default_nettype wire

// ---- flwb_params.svh ----
// Constants for the flash write-latch and boot-read command block.
// Assumes a 20 MHz core clock and a link clock supplied by the host.
`ifndef FLWB_PARAMS_SVH
`define FLWB_PARAMS_SVH

`define FLWB_CLK_MHZ 20
`define FLWB_CFG_WR_TIME_NS 1000
`define FLWB_CFG_WR_CYCLES ((`FLWB_CFG_WR_TIME_NS * `FLWB_CLK_MHZ + 999) / 1000)

`define FLWB_STAT_BUSY 0
`define FLWB_STAT_LATCH 1
`define FLWB_STAT_EFAIL 5
`define FLWB_STAT_PFAIL 6

`define FLWB_CFG_BOOT_EN 0
`define FLWB_CFG_DLY_LSB 1
`define FLWB_CFG_DLY_MSB 8
`define FLWB_CFG_ADDR_LSB 9
`define FLWB_CFG_ADDR_MSB 31
`define FLWB_CFG_RESET 32'h0000_0000

`define FLWB_CMD_BITS 8
`define FLWB_CFG_WR_BITS 40
`define FLWB_ADDR_BITS 24
`define FLWB_ECC_UNIT_LSB 4
`define FLWB_ECC_DUMMY 8
`define FLWB_ECC_REPEAT 16

`endif

// ---- flwb_pkg.sv ----
// Types shared by the flash write-latch and boot-read command block.
// Assumes flwb_params.svh supplies the numeric constants.
`default_nettype none

package flwb_pkg;

  typedef enum logic [7:0] {
    clear_write_enable_cmd = 8'h04,
    set_write_enable_cmd = 8'h06,
    boot_config_write_cmd = 8'h15,
    ecc_status_read_cmd = 8'h18,
    clear_fail_flags_cmd = 8'h30
  } flwb_cmd_t;

  typedef enum logic [2:0] {
    st_cmd = 3'b000,
    st_boot_dly = 3'b001,
    st_boot_data = 3'b010,
    st_ecc_addr = 3'b011,
    st_ecc_dummy = 3'b100,
    st_ecc_data = 3'b101
  } flwb_link_st_t;

endpackage

`default_nettype wire

// ---- flwb_sync.sv ----
// Three-stage synchroniser with agreement filter for asynchronous inputs.
// Assumes the inputs are levels that stay put for several clock periods.
`default_nettype none

module flwb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output var logic [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // The first stage feeds only the second; the output moves once stages two
  // and three agree, so a single metastable sample never reaches the core.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q <= s3_q;
      end
    end
  end

endmodule

`default_nettype wire

// ---- flwb_core_sva.sv ----
// Checker for the write-latch, fail-flag and boot read block.
// Assumes quad_enable and embedded_busy are levels held several clk.
`default_nettype none

module flwb_core_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io_oe_q,
  input wire logic quad_enable,
  input wire logic embedded_busy,
  input wire logic program_fail_evt,
  input wire logic erase_fail_evt,
  input wire logic [31:0] boot_offset_q,
  input wire logic [31:0] boot_base_q,
  input wire logic [19:0] ecc_unit_q,
  input wire logic [7:0] status_register_one_q,
  input wire logic boot_armed_q,
  input wire logic [31:0] boot_config_q,
  input wire logic hw_protect_q
);
  timeunit 1ns;
  timeprecision 100ps;

  AST_PROG_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
    program_fail_evt |-> ##[1:3] status_register_one_q[6]) else $error("program flag");
  AST_ERASE_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
    erase_fail_evt |-> ##[1:3] status_register_one_q[5]) else $error("erase flag");
  AST_FAIL_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
    (status_register_one_q[5] | status_register_one_q[6]) [*3] |-> status_register_one_q[0])
    else $error("busy with flag");
  AST_BUSY_WIP: assert property (@(posedge clk) disable iff (!rst_n)
    embedded_busy [*4] |-> status_register_one_q[0]) else $error("busy bit");
  AST_QUAD_WP: assert property (@(posedge clk) disable iff (!rst_n)
    quad_enable [*6] |-> !hw_protect_q) else $error("protect in quad");
  AST_QUAD_OE: assert property (@(posedge sck) disable iff (cs_n)
    io_oe_q == 4'hf |-> quad_enable) else $error("quad drive");
  AST_ARM_EN: assert property (@(posedge clk) disable iff (!rst_n)
    boot_armed_q |-> boot_config_q[0]) else $error("armed");
  AST_BASE_ALIGN: assert property (@(posedge clk) disable iff (!rst_n)
    boot_base_q[8:0] == 9'h000) else $error("base align");
  AST_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    cs_n |-> io_oe_q == 4'h0 && boot_offset_q == 32'h0 && ecc_unit_q == 20'h0)
    else $error("idle link");
endmodule

bind flwb_core flwb_core_chk chk (.clk, .rst_n, .sck, .cs_n, .io_oe_q, .quad_enable,
  .embedded_busy, .program_fail_evt, .erase_fail_evt, .boot_offset_q, .boot_base_q,
  .ecc_unit_q, .status_register_one_q, .boot_armed_q, .boot_config_q, .hw_protect_q);

`default_nettype wire

// ---- flwb_host.sv ----
// Host model: frames link transfers and captures what the device returns.
// Assumes the device answers on rising sck and holds it one period.
`default_nettype none

module flwb_host (
  output var logic sck,
  output var logic cs_n,
  output wire logic [3:0] io_in,
  input wire logic [3:0] io_out_q,
  input wire logic [3:0] io_oe_q,
  input wire logic wp_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic d0 = 1'h0;
  logic [63:0] rx = 64'h0;

  // Released lines 1 and 3 read high, line 2 follows wp_n; line 0 toggles each clock after the sent bits, so a stale bit cannot pass.
  assign io_in = (io_oe_q & io_out_q) | (~io_oe_q & {1'h1, wp_n, 1'h1, d0});
  initial begin
    sck = 1'h0;
    cs_n = 1'h1;
  end

  // Boot frames carry no bits; sck runs only inside frames.
  task automatic frame(input logic [63:0] tx, input int ntx, input int n, input bit quad);
    cs_n = 1'h0;
    #20;
    for (int i = 0; i < n; i++) begin
      d0 = (i < ntx) ? tx[ntx-1-i] : ~d0;
      #6 sck = 1'h1;
      #6 sck = 1'h0;
      rx = quad ? {rx[59:0], io_out_q} : {rx[62:0], io_out_q[1]};
    end
    #20 cs_n = 1'h1;
    #450;
  endtask
endmodule

`default_nettype wire

// ---- flwb_core_test.sv ----
// Self-checking bench for the write-latch, fail-flag, ECC and boot block.
// Assumes flwb_host drives the link and the checker is bound to the core.
`default_nettype none

module flwb_core_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] CFG = {23'h000003, 8'h04, 1'h1};
  localparam logic [63:0] CFGTX = {24'h0, 8'h15, CFG[7:0], CFG[15:8], CFG[23:16], CFG[31:24]};
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic quad_enable = 1'h0;
  logic embedded_busy = 1'h0;
  logic program_fail_evt = 1'h0;
  logic erase_fail_evt = 1'h0;
  logic cmd_reset_evt = 1'h0;
  logic wp_n = 1'h0;
  wire logic sck, cs_n, hw_protect_q, boot_armed_q;
  wire logic [3:0] io_in, io_out_q, io_oe_q;
  wire logic [7:0] sr, boot_data, ecc_status;
  wire logic [19:0] ecc_unit_q;
  wire logic [31:0] boot_offset_q, boot_base_q, boot_config_q;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;

  // Array stand-ins: data depends on address so a wrong base or unit shows.
  assign boot_data = boot_base_q[16:9] ^ boot_offset_q[7:0];
  assign ecc_status = {ecc_unit_q[3:0], 4'ha};

  flwb_core uut (.clk, .rst_n, .sck, .cs_n, .io_in, .io_out_q, .io_oe_q, .quad_enable,
    .embedded_busy, .program_fail_evt, .erase_fail_evt, .cmd_reset_evt, .boot_data,
    .ecc_status, .boot_offset_q, .boot_base_q, .ecc_unit_q, .status_register_one_q(sr),
    .boot_config_q, .boot_armed_q, .hw_protect_q);
  flwb_host host (.sck, .cs_n, .io_in, .io_out_q, .io_oe_q, .wp_n);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial forever #25 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      test_done();
    end
  end

  initial begin
    w(5);
    rst_n <= 1'h1;
    w(8);
    chk(32'(sr), 32'h0);
    chk(boot_config_q, 32'h0);
    host.frame(64'h06, 8, 8, 0);
    w(8);
    chk(32'(sr), 32'h2);
    // Nine bits whose last eight spell the clear opcode: only the count refuses it.
    host.frame(64'h004, 9, 9, 0);
    w(8);
    chk(32'(sr), 32'h2);
    embedded_busy <= 1'h1;
    host.frame(64'h04, 8, 8, 0);
    w(8);
    chk(32'(sr), 32'h3);
    embedded_busy <= 1'h0;
    $display("test latch done");
    program_fail_evt <= 1'h1;
    erase_fail_evt <= 1'h1;
    w(1);
    program_fail_evt <= 1'h0;
    erase_fail_evt <= 1'h0;
    w(4);
    chk(32'(sr), 32'h63);
    host.frame(64'h30, 8, 8, 0);
    w(8);
    chk(32'(sr), 32'h2);
    $display("test flags done");
    host.frame(64'h04, 8, 8, 0);
    w(8);
    chk(32'(sr), 32'h0);
    host.frame(CFGTX, 40, 40, 0);
    w(40);
    chk(boot_config_q, 32'h0);
    host.frame(64'h06, 8, 8, 0);
    w(8);
    host.frame(CFGTX, 40, 40, 0);
    w(40);
    chk(boot_config_q, CFG);
    chk(32'(sr), 32'h0);
    chk(boot_base_q, 32'h600);
    $display("test config done");
    // Single then quad; the delay of four edges precedes data either way.
    for (int q = 0; q < 2; q++) begin
      quad_enable <= q[0];
      cmd_reset_evt <= 1'h1;
      w(1);
      cmd_reset_evt <= 1'h0;
      w(8);
      chk(32'(boot_armed_q), 32'h1);
      chk(32'(hw_protect_q), 32'(q == 0));
      host.frame(64'h0, 0, q ? 8 : 20, q[0]);
      chk(32'(host.rx[15:0]), 32'h0302);
      w(8);
      chk(32'(boot_armed_q), 32'h0);
      host.frame(64'h04, 8, 8, 0);
      w(8);
      chk(32'(sr[1]), 32'h0);
      host.frame(64'h06, 8, 8, 0);
      w(8);
      chk(32'(sr[1]), 32'h1);
    end
    $display("test boot done");
    quad_enable <= 1'h0;
    w(4);
    host.frame({32'h0, 8'h18, 24'h000120}, 32, 176, 0);
    chk(32'(host.rx[15:0]), 32'h2a3a);
    $display("test ecc done");
    test_done();
  end
endmodule

`default_nettype wire
